// ### dma_source_address_reload.sv
`timescale 1ns/1ps
// Summary of operation
// - Reload restores source start address every four
// - Reload halts after fourth, releases bus
// - Reload off: continue holding bus in burst, advance
// - Reload halt clears requester flag
// - Byte increment advances addresses by one
// - Burst keeps bus between unit transfers
// - Destination follows own mode across reload
// - Count holds transfers, not groups
// - End interrupt only at zero with enable
// - Zero-count flag clear same either mode
// - Reload halt raises no interrupt
// - Priority setting selects 0,2,3,1 order
// - Count decrements once per unit transfer
// - Group counter cleared by stop sources
// - Reload works for byte, word, long
module dma_source_address_reload (
  input  wire logic        I_CORE_CLK,   // 25 MHz core clock
  input  wire logic        I_RST,        // Synchronous reset, high
  input  wire logic        I_STANDBY,    // Standby mode, same domain
  input  wire logic        I_NMI,        // NMI pulse, same domain
  input  wire logic        I_ADDR_ERR,   // Address error pulse
  input  wire logic        I_DREQ,       // Peripheral transfer request
  output logic             O_REQ_CLR,    // Requester flag clear pulse
  output logic             O_BUS_REQ,    // Bus request to CPU
  input  wire logic        I_BUS_GNT,    // Bus grant from CPU
  output dma_reload_pkg::xfer_req_t O_XFER, // Unit transfer command
  input  wire logic        I_XFER_DONE,  // Unit transfer completed
  input  wire logic        I_XFER_ABORT, // Unit transfer aborted
  output logic             O_END_IRQ,    // End-of-transfer interrupt
  output logic [1:0]       O_PRIORITY,   // Channel priority select
  input  wire logic        CYC_I,        // Wishbone cycle
  input  wire logic        STB_I,        // Wishbone strobe
  input  wire logic        WE_I,         // Wishbone write enable
  input  wire logic [7:0]  ADR_I,        // Wishbone byte address
  input  wire logic [3:0]  SEL_I,        // Wishbone byte selects
  input  wire logic [31:0] DAT_I,        // Wishbone write data
  output logic [31:0]      DAT_O,        // Wishbone read data
  output logic             ACK_O,        // Wishbone acknowledge
  output logic             ERR_O         // Wishbone error
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_GNT,
    ST_XFER,
    ST_WAIT_DONE
  } state_t;

  state_t             state_r;
  logic [31:0]        src_start_r;
  logic [31:0]        src_r;
  logic [31:0]        dst_r;
  logic [31:0]        cnt_r;
  logic [31:0]        ctrl_r;
  logic [15:0]        oper_r;
  logic               irq_r;
  logic               req_clr_r;
  logic               last_unit;
  logic               grp_clr;
  logic               stop_all;
  logic               unit_done;
  logic               zero_next;
  logic               wb_req;
  logic               wb_hit;
  logic               wb_wr;
  logic               te_set;
  logic [31:0]        step;
  logic [31:0]        wmask;
  dma_reload_pkg::chan_cfg_t cfg;

  assign cfg.reload_en = ctrl_r[dma_reload_pkg::CTRL_RELOAD_BIT];
  assign cfg.burst     = ctrl_r[dma_reload_pkg::CTRL_BURST_BIT];
  assign cfg.size      = dma_reload_pkg::size_t'(ctrl_r[dma_reload_pkg::CTRL_TS_LSB +: 2]);
  assign cfg.src_mode  = dma_reload_pkg::addr_mode_t'(ctrl_r[dma_reload_pkg::CTRL_SM_LSB +: 2]);
  assign cfg.dst_mode  = dma_reload_pkg::addr_mode_t'(ctrl_r[dma_reload_pkg::CTRL_DM_LSB +: 2]);
  assign cfg.irq_en    = ctrl_r[dma_reload_pkg::CTRL_IE_BIT];
  assign cfg.chan_en   = ctrl_r[dma_reload_pkg::CTRL_DE_BIT];

  assign stop_all = oper_r[dma_reload_pkg::OPER_NMI_STOP_FLAG_BIT] | oper_r[dma_reload_pkg::OPER_AE_BIT]
                  | ~oper_r[dma_reload_pkg::OPER_DME_BIT];
  assign unit_done = (state_r == ST_WAIT_DONE) && I_XFER_DONE;
  assign zero_next = (cnt_r == 32'h0000_0001);
  assign te_set    = unit_done && zero_next;

  always_comb begin
    case (cfg.size)
      dma_reload_pkg::SZ_WORD: step = 32'h0000_0002;
      dma_reload_pkg::SZ_LONG: step = 32'h0000_0004;
      default:                 step = 32'h0000_0001;
    endcase
  end

  function automatic logic [31:0] adv(input logic [31:0] a,
                                      input dma_reload_pkg::addr_mode_t m,
                                      input logic [31:0] s);
    case (m)
      dma_reload_pkg::AM_INC: adv = a + s;
      dma_reload_pkg::AM_DEC: adv = a - s;
      default:                adv = a;
    endcase
  endfunction : adv

  // Group counter reset sources; an abort counts only when done arrives in the same cycle
  assign grp_clr = I_RST | I_STANDBY | I_NMI | I_ADDR_ERR | stop_all | ~cfg.chan_en
                 | te_set;

  dma_group_counter #(
    .GROUP (dma_reload_pkg::GROUP_SIZE)
  ) u_group (
    .i_clk  (I_CORE_CLK),
    .i_clr  (grp_clr),
    .i_step (unit_done && cfg.reload_en),
    .o_last (last_unit)
  );

  // Channel sequencer
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || I_STANDBY) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          // Requester flag still reads set while its clear pulse is out
          if (I_DREQ && cfg.chan_en && !stop_all && !ctrl_r[dma_reload_pkg::CTRL_TE_BIT]
              && cnt_r != 32'h0 && !req_clr_r)
            state_r <= ST_WAIT_GNT;
        end
        ST_WAIT_GNT: begin
          if (stop_all || !cfg.chan_en)
            state_r <= ST_IDLE;
          else if (I_BUS_GNT)
            state_r <= ST_XFER;
        end
        ST_XFER: state_r <= ST_WAIT_DONE;
        ST_WAIT_DONE: begin
          if (I_XFER_ABORT)
            state_r <= ST_IDLE;
          else if (I_XFER_DONE) begin
            if (zero_next || last_unit || stop_all || !cfg.chan_en || I_NMI || I_ADDR_ERR)
              state_r <= ST_IDLE;
            else if (cfg.burst)
              state_r <= ST_XFER;
            else
              state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign O_BUS_REQ = (state_r != ST_IDLE);
  assign O_REQ_CLR = req_clr_r;
  assign O_END_IRQ = irq_r;
  assign O_PRIORITY = oper_r[dma_reload_pkg::OPER_PR_LSB +: 2];

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_XFER <= '0;
    end else begin
      O_XFER.valid <= (state_r == ST_XFER) ? 1'b0 : O_XFER.valid;
      if (state_r == ST_WAIT_GNT && I_BUS_GNT || state_r == ST_WAIT_DONE && I_XFER_DONE)
        O_XFER.valid <= 1'b0;
      if (state_r == ST_XFER) begin
        O_XFER.valid <= 1'b1;
        O_XFER.src   <= src_r;
        O_XFER.dst   <= dst_r;
        O_XFER.size  <= cfg.size;
      end else begin
        O_XFER.valid <= 1'b0;
      end
    end
  end

  // Requester clear on reload halt and on count end
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      req_clr_r <= 1'b0;
    end else begin
      req_clr_r <= unit_done && ((last_unit && cfg.reload_en) || zero_next);
    end
  end

  // Interrupt: only at count zero, never at reload halt
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= cfg.irq_en && ctrl_r[dma_reload_pkg::CTRL_TE_BIT];
    end
  end

  assign wb_req = CYC_I && STB_I && !ACK_O && !ERR_O;
  assign wb_hit = (ADR_I[1:0] == 2'h0) && (ADR_I <= dma_reload_pkg::OFS_STATUS);
  assign wmask  = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
  // Writes land at the edge where the master sees ack
  assign wb_wr  = CYC_I && STB_I && WE_I && ACK_O;

  // Address and count registers
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      src_start_r <= 32'h0;
      src_r       <= 32'h0;
      dst_r       <= 32'h0;
      cnt_r       <= 32'h0;
    end else if (unit_done) begin
      src_r <= (cfg.reload_en && last_unit) ? src_start_r
             : adv(src_r, cfg.src_mode, step);
      dst_r <= adv(dst_r, cfg.dst_mode, step);
      cnt_r <= cnt_r - 32'h1;
    end else if (wb_wr) begin
      case (ADR_I)
        dma_reload_pkg::OFS_SRC_ADDR: begin
          src_start_r <= (src_r & ~wmask) | (DAT_I & wmask);
          src_r       <= (src_r & ~wmask) | (DAT_I & wmask);
        end
        dma_reload_pkg::OFS_DST_ADDR: dst_r <= (dst_r & ~wmask) | (DAT_I & wmask);
        dma_reload_pkg::OFS_COUNT:    cnt_r <= (cnt_r & ~wmask) | (DAT_I & wmask);
        default: ;
      endcase
    end
  end

  // Control and operation registers; hardware set wins over clear
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      ctrl_r <= dma_reload_pkg::CTRL_RESET;
      oper_r <= dma_reload_pkg::OPER_RESET;
    end else begin
      if (wb_wr && ADR_I == dma_reload_pkg::OFS_CTRL)
        ctrl_r <= (ctrl_r & ~wmask) | (DAT_I & wmask);
      if (wb_wr && ADR_I == dma_reload_pkg::OFS_OPER)
        oper_r <= (oper_r & ~wmask[15:0]) | (DAT_I[15:0] & wmask[15:0]);
      if (te_set)
        ctrl_r[dma_reload_pkg::CTRL_TE_BIT] <= 1'b1;
      if (I_NMI)
        oper_r[dma_reload_pkg::OPER_NMI_STOP_FLAG_BIT] <= 1'b1;
      if (I_ADDR_ERR)
        oper_r[dma_reload_pkg::OPER_AE_BIT] <= 1'b1;
    end
  end

  // Wishbone answer one cycle after request
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      ACK_O <= 1'b0;
      ERR_O <= 1'b0;
      DAT_O <= 32'h0;
    end else begin
      ACK_O <= wb_req && wb_hit;
      ERR_O <= wb_req && !wb_hit;
      DAT_O <= 32'h0;
      if (wb_req && wb_hit && !WE_I) begin
        case (ADR_I)
          dma_reload_pkg::OFS_SRC_ADDR: DAT_O <= src_r;
          dma_reload_pkg::OFS_DST_ADDR: DAT_O <= dst_r;
          dma_reload_pkg::OFS_COUNT:    DAT_O <= cnt_r;
          dma_reload_pkg::OFS_CTRL:     DAT_O <= ctrl_r;
          dma_reload_pkg::OFS_OPER:     DAT_O <= {16'h0, oper_r};
          default:                      DAT_O <= {28'h0, state_r, O_BUS_REQ, irq_r};
        endcase
      end
    end
  end

  // Checks
  reload_restore_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    unit_done && cfg.reload_en && last_unit |=> src_r == $past(src_start_r))
    else $error("source not restored at group end");
  reload_halt_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    unit_done && !I_XFER_ABORT && cfg.reload_en && last_unit |=> state_r == ST_IDLE)
    else $error("channel kept bus at reload point");
  norel_adv_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    unit_done && !cfg.reload_en |=> src_r == adv($past(src_r), $past(cfg.src_mode), $past(step)))
    else $error("source did not advance");
  req_clear_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    unit_done && cfg.reload_en && last_unit |=> O_REQ_CLR)
    else $error("requester flag not cleared");
  burst_keep_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    unit_done && !I_XFER_ABORT && cfg.burst && !last_unit && !zero_next && !stop_all
    && cfg.chan_en && !I_NMI && !I_ADDR_ERR && !I_STANDBY |=> O_BUS_REQ [*2])
    else $error("bus dropped in burst");
  dst_adv_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    unit_done |=> dst_r == adv($past(dst_r), $past(cfg.dst_mode), $past(step)))
    else $error("destination update wrong");
  cnt_dec_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    unit_done |=> cnt_r == $past(cnt_r) - 32'h1)
    else $error("count not decremented");
  irq_cause_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    $rose(O_END_IRQ) |-> $past(ctrl_r[dma_reload_pkg::CTRL_TE_BIT]) && $past(cfg.irq_en))
    else $error("interrupt without count end");
  zero_clr_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    te_set |=> O_REQ_CLR ##1 ctrl_r[dma_reload_pkg::CTRL_TE_BIT])
    else $error("zero count clear missing");

endmodule : dma_source_address_reload

// ### dma_reload_pkg.sv
package dma_reload_pkg;

  localparam int          ADDR_W          = 32;
  localparam int          DATA_W          = 32;
  localparam int          GROUP_SIZE      = 4;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0]  OFS_SRC_ADDR    = 8'h00;
  localparam logic [7:0]  OFS_DST_ADDR    = 8'h04;
  localparam logic [7:0]  OFS_COUNT       = 8'h08;
  localparam logic [7:0]  OFS_CTRL        = 8'h0c;
  localparam logic [7:0]  OFS_OPER        = 8'h10;
  localparam logic [7:0]  OFS_STATUS      = 8'h14;

  // Channel control field positions
  localparam int          CTRL_DE_BIT     = 0;
  localparam int          CTRL_IE_BIT     = 2;
  localparam int          CTRL_TE_BIT     = 1;
  localparam int          CTRL_TS_LSB     = 3;
  localparam int          CTRL_BURST_BIT  = 5;
  localparam int          CTRL_RELOAD_BIT = 6;
  localparam int          CTRL_SM_LSB     = 8;
  localparam int          CTRL_DM_LSB     = 10;

  // Operation register field positions
  localparam int          OPER_DME_BIT    = 0;
  localparam int          OPER_NMI_STOP_FLAG_BIT   = 1;
  localparam int          OPER_AE_BIT     = 2;
  localparam int          OPER_PR_LSB     = 8;

  // Reset values
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam logic [15:0] OPER_RESET      = 16'h0000;

  // Priority order value 0 > 2 > 3 > 1
  localparam logic [1:0]  PRI_0_2_3_1     = 2'h1;

  typedef enum logic [1:0] {
    SZ_BYTE,
    SZ_WORD,
    SZ_LONG,
    SZ_RSVD
  } size_t;

  typedef enum logic [1:0] {
    AM_FIXED,
    AM_INC,
    AM_DEC,
    AM_RSVD
  } addr_mode_t;

  typedef struct packed {
    logic        reload_en;
    logic        burst;
    size_t       size;
    addr_mode_t  src_mode;
    addr_mode_t  dst_mode;
    logic        irq_en;
    logic        chan_en;
  } chan_cfg_t;

  typedef struct packed {
    logic                 valid;
    logic [ADDR_W-1:0]    src;
    logic [ADDR_W-1:0]    dst;
    size_t                size;
  } xfer_req_t;

endpackage : dma_reload_pkg

// ### dma_group_counter.sv
`timescale 1ns/1ps
module dma_group_counter #(
  parameter int GROUP = 4
) (
  input  wire logic i_clk,   // Core clock
  input  wire logic i_clr,   // Synchronous clear
  input  wire logic i_step,  // One completed unit
  output logic      o_last   // Step completes the group
);

  localparam int CW = $clog2(GROUP);

  logic [CW-1:0] cnt_r;

  if (GROUP < 2 || (GROUP & (GROUP - 1)) != 0) begin : g_bad_group
    $error("GROUP must be a power of two of at least 2");
  end

  assign o_last = i_step && (cnt_r == CW'(GROUP - 1));

  always_ff @(posedge i_clk) begin
    if (i_clr) begin
      cnt_r <= '0;
    end else if (i_step) begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  grp_clear_a: assert property (@(posedge i_clk) i_clr |=> cnt_r == '0)
    else $error("group count not cleared");
  grp_hold_a: assert property (@(posedge i_clk) !i_clr && !i_step |=> $stable(cnt_r))
    else $error("group count moved without a unit");

endmodule : dma_group_counter

// ### dma_far_model.sv
`timescale 1ns/1ps
module dma_far_model (
  input  wire logic       i_clk,      // Core clock
  input  wire logic       i_rst,      // Sync reset, high
  input  wire logic       i_go,       // Raise a fresh request
  input  wire logic [3:0] i_lat,      // Extra cycles per unit
  input  wire logic       i_bus_req,  // Bus request from channel
  input  wire logic       i_req_clr,  // Flag clear from channel
  input  wire logic       i_valid,    // Unit command
  output logic            o_dreq,     // Requester flag
  output logic            o_gnt,      // Bus grant
  output logic            o_done      // Unit completed
);
  logic [3:0] wait_r;
  logic       busy_r;

  // Flag stays set until the channel clears it
  always_ff @(posedge i_clk) begin
    if (i_rst) o_dreq <= 1'b0;
    else if (i_req_clr) o_dreq <= 1'b0;
    else if (i_go) o_dreq <= 1'b1;
  end

  always_ff @(posedge i_clk) begin
    o_gnt <= !i_rst && i_bus_req;
  end

  // Prompt or slow completion of each unit
  always_ff @(posedge i_clk) begin
    o_done <= 1'b0;
    if (i_rst) begin
      busy_r <= 1'b0;
      wait_r <= 4'h0;
    end else if (i_valid) begin
      busy_r <= 1'b1;
      wait_r <= i_lat;
    end else if (busy_r && wait_r == 4'h0) begin
      busy_r <= 1'b0;
      o_done <= 1'b1;
    end else if (busy_r) begin
      wait_r <= wait_r - 4'h1;
    end
  end
endmodule : dma_far_model

// ### tb.sv
`timescale 1ns/1ps
module tb;
  logic clk, rst, go, cyc, stb, we, ack, err, dreq, gnt, done, req_clr, bus_req, irq;
  logic abort, nmi;
  logic [1:0]  fault;
  logic [3:0]  lat, sel;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [1:0]  pri;
  logic        e, bus_q;
  dma_reload_pkg::xfer_req_t xfer;
  logic [31:0] sq[$];
  logic [31:0] dq[$];
  int n_fail, compares, n_clr, n_rel, i, r0;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  dma_source_address_reload dut_u (
    .I_CORE_CLK(clk), .I_RST(rst), .I_STANDBY(1'b0), .I_NMI(nmi), .I_ADDR_ERR(1'b0),
    .I_DREQ(dreq), .O_REQ_CLR(req_clr), .O_BUS_REQ(bus_req), .I_BUS_GNT(gnt),
    .O_XFER(xfer), .I_XFER_DONE(done), .I_XFER_ABORT(abort), .O_END_IRQ(irq),
    .O_PRIORITY(pri), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
    .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .ERR_O(err));

  dma_far_model far_u (
    .i_clk(clk), .i_rst(rst), .i_go(go), .i_lat(lat), .i_bus_req(bus_req),
    .i_req_clr(req_clr), .i_valid(xfer.valid), .o_dreq(dreq), .o_gnt(gnt), .o_done(done));

  always @(negedge clk) begin
    bus_q <= bus_req;
    if (xfer.valid === 1'b1) begin
      sq.push_back(xfer.src);
      dq.push_back(xfer.dst);
    end
    if (req_clr === 1'b1) n_clr++;
    if (bus_q === 1'b1 && bus_req === 1'b0) n_rel++;
  end

  // Abort the first unit, or raise NMI during the second one
  always @(posedge clk) begin
    abort <= fault == 2'h1 && xfer.valid === 1'b1 && sq.size() == 1;
    nmi   <= fault == 2'h2 && xfer.valid === 1'b1 && sq.size() == 2;
  end

  task automatic give_verdict;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (ack === 1'b1 || err === 1'b1) break;
    end
    q = rdat;
    e = err;
    cyc <= 1'b0; stb <= 1'b0;
    if (k == 50) begin
      n_fail++;
      give_verdict();
    end
  endtask : wb

  task automatic setup(input logic [31:0] cnt, input logic [31:0] ctrl);
    sq.delete();
    dq.delete();
    wb(1'b1, dma_reload_pkg::OFS_SRC_ADDR, 32'hffff83f0);
    wb(1'b1, dma_reload_pkg::OFS_DST_ADDR, 32'hfffff000);
    wb(1'b1, dma_reload_pkg::OFS_COUNT, cnt);
    wb(1'b1, dma_reload_pkg::OFS_CTRL, ctrl);
  endtask : setup

  task automatic kick(input int n, input bit rel = 1'b0);
    int k;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (k = 0; k < 400 && (rel ? n_rel : n_clr) < n; k++) @(negedge clk);
    if (k == 400) begin
      n_fail++;
      give_verdict();
    end
    repeat (3) @(posedge clk);
  endtask : kick

  initial begin
    rst = 1'b1; go = 1'b0; lat = 4'h0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 8'h00; wdat = 32'h0; sel = 4'h0; bus_q = 1'b0;
    fault = 2'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // Reload on, burst, byte, count a multiple of four
    setup(32'h8, 32'h565);
    wb(1'b1, dma_reload_pkg::OFS_OPER, 32'h0101);
    @(negedge clk);
    chk({30'h0, pri}, 32'h1);
    kick(1);
    chk(sq.size(), 32'h4);
    chk(n_rel, 32'h1);
    chk({31'h0, bus_req}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wb(1'b0, dma_reload_pkg::OFS_SRC_ADDR, 32'h0);
    chk(q, 32'hffff83f0);
    wb(1'b0, dma_reload_pkg::OFS_COUNT, 32'h0);
    chk(q, 32'h4);
    kick(2);
    chk(sq.size(), 32'h8);
    for (i = 0; i < 8; i++) begin
      chk(sq[i], 32'hffff83f0 + (i % 4));
      chk(dq[i], 32'hfffff000 + i);
    end
    wb(1'b0, dma_reload_pkg::OFS_COUNT, 32'h0);
    chk(q, 32'h0);
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    wb(1'b0, 8'h18, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("test reload_on done");
    // Reload off, slow completions
    lat <= 4'h3;
    r0 = n_rel;
    setup(32'h6, 32'h525);
    kick(3);
    chk(sq.size(), 32'h6);
    chk(n_rel, r0 + 1);
    for (i = 0; i < 6; i++) chk(sq[i], 32'hffff83f0 + i);
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    $display("test reload_off done");
    // Word size with reload
    lat <= 4'h0;
    setup(32'h4, 32'h56d);
    kick(4);
    chk(sq[3], 32'hffff83f6);
    chk(dq[3], 32'hfffff006);
    $display("test word_size done");
    // Aborted unit is repeated and not counted
    fault <= 2'h1;
    setup(32'h4, 32'h565);
    kick(5);
    chk(sq.size(), 32'h5);
    chk(sq[1], 32'hffff83f0);
    chk(sq[4], 32'hffff83f3);
    chk(dq[4], 32'hfffff003);
    $display("test abort done");
    // NMI mid-group restarts the group count, registers kept
    fault <= 2'h2;
    setup(32'h8, 32'h565);
    r0 = n_rel;
    kick(r0 + 1, 1'b1);
    chk(sq.size(), 32'h2);
    wb(1'b0, dma_reload_pkg::OFS_OPER, 32'h0);
    chk(q, 32'h0103);
    wb(1'b0, dma_reload_pkg::OFS_COUNT, 32'h0);
    chk(q, 32'h6);
    wb(1'b1, dma_reload_pkg::OFS_OPER, 32'h0101);
    kick(6);
    chk(sq.size(), 32'h6);
    chk(sq[5], 32'hffff83f5);
    wb(1'b0, dma_reload_pkg::OFS_SRC_ADDR, 32'h0);
    chk(q, 32'hffff83f0);
    wb(1'b0, dma_reload_pkg::OFS_COUNT, 32'h0);
    chk(q, 32'h2);
    $display("test nmi_restart done");
    give_verdict();
  end
endmodule : tb
